// ---- tmr2_pkg.sv ----
// Constants, register map and types for the timer 2 baud and interrupt block
// ---------------------------------------------------------------------------
// Operation
// - Baud mode rollover sets no overflow flag and raises no interrupt
// - Baud mode with edge enable: pin falling edge sets edge flag, no reload
// - Internal baud clock is oscillator over 32 times (65536 minus reload)
// - External baud clock is the timer overflow rate over 16
// - Baud mode timer function counts on every state time
// - Either clock select with run gives baud mode; run clear stops the timer
// - Otherwise capture select picks auto-reload (0) or capture (1)
// - Timer setup codes map straight onto the control register bits
// - Counter setup codes 02H, 0AH, 03H, 0BH select external pin counting
// - Reload on overflow in reload and baud modes, not in capture; with edge enable, capture or reload on pin fall
// - Timer 2 request is the OR of overflow flag and edge flag
// - Vectoring to timer 2 leaves both of its flags untouched
// - Software writes to request flags act like hardware set or clear
// - Six sources, fixed order within each of two priority levels, vectors 0003H to 002BH
// - Enable and priority registers carry a like bit for timer 2
// ---------------------------------------------------------------------------
package tmr2_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CNT_LO = 8'h04;
  localparam logic [7:0] ADDR_CNT_HI = 8'h08;
  localparam logic [7:0] ADDR_RLD_LO = 8'h0C;
  localparam logic [7:0] ADDR_RLD_HI = 8'h10;
  localparam logic [7:0] ADDR_INT_EN = 8'h14;
  localparam logic [7:0] ADDR_INT_PRI = 8'h18;
  localparam logic [7:0] ADDR_EVT_STAT = 8'h1C;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h20;
  localparam logic [7:0] ADDR_VECT = 8'h24;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] RLD_RST = 16'h0000;
  localparam logic [7:0] INT_EN_RST = 8'h00;
  localparam logic [5:0] INT_PRI_RST = 6'h00;
  localparam logic [1:0] EVT_RST = 2'h0;
  // Field positions
  localparam int INT_EN_GLOBAL = 7;
  localparam int EVT_OVF = 0;
  localparam int EVT_EDGE = 1;
  localparam int NUM_SRC = 6;
  localparam int SRC_TIMER2 = 5;
  // Timing counts
  localparam logic [3:0] OSC_PER_MACHINE = 4'hC;
  localparam logic [3:0] BAUD_DIV = 4'hF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // Vector table
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic timer2_overflow_flag;
    logic external_edge_flag;
    logic rx_clock_select;
    logic tx_clock_select;
    logic external_edge_enable;
    logic timer2_run;
    logic count_select;
    logic capture_not_reload_select;
  } tmr2_ctrl_t;

  typedef enum {REG_CTRL, REG_CNT_LO, REG_CNT_HI, REG_RLD_LO, REG_RLD_HI, REG_INT_EN,
                REG_INT_PRI, REG_EVT_STAT, REG_EVT_MASK, REG_VECT, REG_NONE} tmr2_reg_t;
endpackage : tmr2_pkg

// ---- tmr2_top.sv ----
// Timer 2 with baud generation, interrupt vectoring and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module tmr2_top
  import tmr2_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Pins
  input wire logic count_input_pin,
  input wire logic capture_reload_pin,
  // CPU core interrupt side
  input wire logic [4:0] src_req,
  input wire logic int_ack,
  output logic int_req,
  output logic [15:0] int_vector,
  output logic int_level,
  // Serial port
  input wire logic timer1_baud_tick,
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  // Interrupt
  output logic irq
);

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  function automatic tmr2_reg_t decode(input logic [7:0] a);
    if (a == ADDR_CTRL) decode = REG_CTRL;
    else if (a == ADDR_CNT_LO) decode = REG_CNT_LO;
    else if (a == ADDR_CNT_HI) decode = REG_CNT_HI;
    else if (a == ADDR_RLD_LO) decode = REG_RLD_LO;
    else if (a == ADDR_RLD_HI) decode = REG_RLD_HI;
    else if (a == ADDR_INT_EN) decode = REG_INT_EN;
    else if (a == ADDR_INT_PRI) decode = REG_INT_PRI;
    else if (a == ADDR_EVT_STAT) decode = REG_EVT_STAT;
    else if (a == ADDR_EVT_MASK) decode = REG_EVT_MASK;
    else if (a == ADDR_VECT) decode = REG_VECT;
    else decode = REG_NONE;
  endfunction : decode

  tmr2_ctrl_t ctrl_r;
  logic [15:0] cnt_r, rld_r;
  logic [7:0] int_en_r;
  logic [5:0] int_pri_r;
  logic [1:0] evt_stat_r, evt_mask_r;
  logic [15:0] ack_vector_r;

  // ---------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------------------
  logic awready_r, wready_r, bvalid_r, aw_held_r, w_held_r;
  logic [7:0] waddr_r;
  logic [7:0] wbyte_r;
  logic wlane_r;
  logic wr_go;
  tmr2_reg_t wr_reg;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign wr_reg = decode(waddr_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= 8'h00;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready_r) begin
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
        waddr_r <= awaddr;
      end
      if (wvalid && wready_r) begin
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
        wbyte_r <= wdata[7:0];
        wlane_r <= wstrb[0];
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp <= (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;

  logic wr_en;
  assign wr_en = wr_go && wlane_r;

  // ---------------------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ---------------------------------------------------------------------------
  logic [1:0] cnt_pin_s1_r, cnt_pin_s2_r, cnt_pin_d_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_pin_s1_r <= 2'h3;
      cnt_pin_s2_r <= 2'h3;
      cnt_pin_d_r <= 2'h3;
    end else begin
      cnt_pin_s1_r <= {capture_reload_pin, count_input_pin};
      cnt_pin_s2_r <= cnt_pin_s1_r;
      cnt_pin_d_r <= cnt_pin_s2_r;
    end
  end
  logic t2_fall, edge_fall;
  assign t2_fall = cnt_pin_d_r[0] && !cnt_pin_s2_r[0];
  assign edge_fall = cnt_pin_d_r[1] && !cnt_pin_s2_r[1];

  // ---------------------------------------------------------------------------
  // Prescaler: state time every 2 clocks, machine cycle every 12
  // ---------------------------------------------------------------------------
  logic [3:0] pre_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) pre_r <= 4'h0;
    else if (pre_r == OSC_PER_MACHINE - 4'h1) pre_r <= 4'h0;
    else pre_r <= pre_r + 4'h1;
  end
  logic state_tick, machine_tick;
  assign state_tick = pre_r[0];
  assign machine_tick = (pre_r == OSC_PER_MACHINE - 4'h1);

  // ---------------------------------------------------------------------------
  // Mode decode and count
  // ---------------------------------------------------------------------------
  logic baud_sel, baud_mode, cnt_tick, ovf, capture_mode, edge_evt, edge_act;
  assign baud_sel = ctrl_r.rx_clock_select || ctrl_r.tx_clock_select;
  assign baud_mode = baud_sel && ctrl_r.timer2_run;
  assign capture_mode = !baud_sel && ctrl_r.capture_not_reload_select;
  assign cnt_tick = ctrl_r.timer2_run && (ctrl_r.count_select ? t2_fall :
                    (baud_mode ? state_tick : machine_tick));
  assign ovf = cnt_tick && (cnt_r == CNT_MAX);
  assign edge_evt = ctrl_r.external_edge_enable && edge_fall;
  assign edge_act = edge_evt && !baud_sel;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= CNT_RST;
    end else begin
      if (ovf && !capture_mode) cnt_r <= rld_r;
      else if (cnt_tick) cnt_r <= cnt_r + 16'h0001;
      if (edge_act && !capture_mode) cnt_r <= rld_r;
      if (wr_en && wr_reg == REG_CNT_LO) cnt_r[7:0] <= wbyte_r;
      if (wr_en && wr_reg == REG_CNT_HI) cnt_r[15:8] <= wbyte_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rld_r <= RLD_RST;
    end else begin
      if (edge_act && capture_mode) rld_r <= cnt_r;
      if (wr_en && wr_reg == REG_RLD_LO) rld_r[7:0] <= wbyte_r;
      if (wr_en && wr_reg == REG_RLD_HI) rld_r[15:8] <= wbyte_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Control register and flags
  // ---------------------------------------------------------------------------
  logic ovf_set;
  assign ovf_set = ovf && !baud_sel;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_en && wr_reg == REG_CTRL) begin
      ctrl_r <= wbyte_r;
      if (ovf_set) ctrl_r.timer2_overflow_flag <= 1'b1;
      if (edge_evt) ctrl_r.external_edge_flag <= 1'b1;
    end else begin
      if (ovf_set) ctrl_r.timer2_overflow_flag <= 1'b1;
      if (edge_evt) ctrl_r.external_edge_flag <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Baud ticks to the serial port
  // ---------------------------------------------------------------------------
  logic [3:0] baud_div_r;
  logic t2_baud;
  logic rx_baud_r, tx_baud_r;
  assign t2_baud = baud_mode && ovf && (baud_div_r == BAUD_DIV);
  always_ff @(posedge aclk) begin
    if (!aresetn) baud_div_r <= 4'h0;
    else if (!baud_mode) baud_div_r <= 4'h0;
    else if (ovf) baud_div_r <= baud_div_r + 4'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_baud_r <= 1'b0;
      tx_baud_r <= 1'b0;
    end else begin
      rx_baud_r <= ctrl_r.rx_clock_select ? t2_baud : timer1_baud_tick;
      tx_baud_r <= ctrl_r.tx_clock_select ? t2_baud : timer1_baud_tick;
    end
  end
  assign rx_baud_tick = rx_baud_r;
  assign tx_baud_tick = tx_baud_r;

  // ---------------------------------------------------------------------------
  // Interrupt vectoring
  // ---------------------------------------------------------------------------
  logic [5:0] req_all;
  logic sel_found, sel_level;
  logic [2:0] sel_idx;
  assign req_all = {ctrl_r.timer2_overflow_flag || ctrl_r.external_edge_flag, src_req};

  always_comb begin
    sel_found = 1'b0;
    sel_level = 1'b0;
    sel_idx = 3'h0;
    for (int lv = 1; lv >= 0; lv--) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (!sel_found && int_en_r[INT_EN_GLOBAL] && int_en_r[i] && req_all[i] &&
            int_pri_r[i] == lv[0]) begin
          sel_found = 1'b1;
          sel_level = lv[0];
          sel_idx = i[2:0];
        end
      end
    end
  end

  logic int_req_r, int_level_r;
  logic [15:0] int_vector_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_req_r <= 1'b0;
      int_level_r <= 1'b0;
      int_vector_r <= VEC_BASE;
      ack_vector_r <= VEC_BASE;
    end else begin
      int_req_r <= sel_found;
      int_level_r <= sel_level;
      int_vector_r <= VEC_BASE + VEC_STEP * {13'h0000, sel_idx};
      if (int_ack) ack_vector_r <= int_vector_r;
    end
  end
  assign int_req = int_req_r;
  assign int_level = int_level_r;
  assign int_vector = int_vector_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_en_r <= INT_EN_RST;
      int_pri_r <= INT_PRI_RST;
      evt_mask_r <= EVT_RST;
    end else if (wr_en) begin
      if (wr_reg == REG_INT_EN) int_en_r <= wbyte_r;
      if (wr_reg == REG_INT_PRI) int_pri_r <= wbyte_r[5:0];
      if (wr_reg == REG_EVT_MASK) evt_mask_r <= wbyte_r[1:0];
    end
  end

  // Sticky events, write one to clear, set wins
  logic [1:0] evt_set, evt_clr;
  assign evt_set = {edge_evt, ovf_set};
  assign evt_clr = (wr_en && wr_reg == REG_EVT_STAT) ? wbyte_r[1:0] : 2'h0;
  logic irq_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_stat_r <= EVT_RST;
      irq_r <= 1'b0;
    end else begin
      evt_stat_r <= (evt_stat_r & ~evt_clr) | evt_set;
      irq_r <= |(evt_stat_r & evt_mask_r);
    end
  end
  assign irq = irq_r;

  // ---------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------------------
  logic arready_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  tmr2_reg_t rd_reg;
  assign rd_reg = decode(araddr);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= (rd_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (rd_reg == REG_CTRL) rdata_r <= {24'h000000, ctrl_r};
      else if (rd_reg == REG_CNT_LO) rdata_r <= {24'h000000, cnt_r[7:0]};
      else if (rd_reg == REG_CNT_HI) rdata_r <= {24'h000000, cnt_r[15:8]};
      else if (rd_reg == REG_RLD_LO) rdata_r <= {24'h000000, rld_r[7:0]};
      else if (rd_reg == REG_RLD_HI) rdata_r <= {24'h000000, rld_r[15:8]};
      else if (rd_reg == REG_INT_EN) rdata_r <= {24'h000000, int_en_r};
      else if (rd_reg == REG_INT_PRI) rdata_r <= {26'h0000000, int_pri_r};
      else if (rd_reg == REG_EVT_STAT) rdata_r <= {30'h00000000, evt_stat_r};
      else if (rd_reg == REG_EVT_MASK) rdata_r <= {30'h00000000, evt_mask_r};
      else if (rd_reg == REG_VECT) rdata_r <= {ack_vector_r, int_vector_r};
      else rdata_r <= 32'h0000_0000;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_baud_no_flag;
    baud_sel && ovf && !(wr_en && wr_reg == REG_CTRL) && !ctrl_r.timer2_overflow_flag
      |=> !ctrl_r.timer2_overflow_flag;
  endproperty
  a_baud_no_flag: assert property (p_baud_no_flag) else $error("baud rollover set flag");

  property p_edge_no_reload;
    baud_sel && edge_evt && !cnt_tick && !wr_en |=> ctrl_r.external_edge_flag &&
      cnt_r == $past(cnt_r);
  endproperty
  a_edge_no_reload: assert property (p_edge_no_reload) else $error("baud edge reloaded");

  property p_reload_on_ovf;
    ovf && !capture_mode && !wr_en |=> cnt_r == $past(rld_r);
  endproperty
  a_reload_on_ovf: assert property (p_reload_on_ovf) else $error("no reload on overflow");

  property p_baud_div;
    baud_mode && ovf && baud_div_r == BAUD_DIV |=> baud_div_r == 4'h0;
  endproperty
  a_baud_div: assert property (p_baud_div) else $error("baud divider not by 16");

  property p_state_rate;
    baud_mode && !ctrl_r.count_select && cnt_r != CNT_MAX && !wr_en && !edge_act ##1
      baud_mode && !wr_en && !edge_act |=> cnt_r == $past(cnt_r, 2) + 16'h0001;
  endproperty
  a_state_rate: assert property (p_state_rate) else $error("baud count not each state");

  property p_off_hold;
    !ctrl_r.timer2_run && !edge_act && !wr_en |=> cnt_r == $past(cnt_r);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("stopped timer moved");

  property p_capture;
    capture_mode && edge_act && !wr_en |=> rld_r == $past(cnt_r);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");

  property p_ack_keeps_flags;
    int_ack && !(wr_en && wr_reg == REG_CTRL) && req_all[SRC_TIMER2] |=> req_all[SRC_TIMER2];
  endproperty
  a_ack_keeps_flags: assert property (p_ack_keeps_flags) else $error("ack cleared flag");

  property p_sw_set;
    wr_en && wr_reg == REG_CTRL && wbyte_r[7] |=> ctrl_r.timer2_overflow_flag;
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("software set lost");

  property p_vector;
    sel_found && sel_idx == 3'h5 |=> int_req && int_vector == 16'h002B;
  endproperty
  a_vector: assert property (p_vector) else $error("timer 2 vector wrong");

  property p_route;
    ctrl_r.rx_clock_select && t2_baud |=> rx_baud_tick;
  endproperty
  a_route: assert property (p_route) else $error("rx baud not routed");

  c_baud_tick: cover property (baud_mode ##[1:300] t2_baud);
  c_capture: cover property (capture_mode && edge_act);
  c_t2_vector: cover property (int_req && int_vector == 16'h002B);
  c_irq: cover property (irq);

endmodule : tmr2_top
`default_nettype wire

// ---- tmr2_serial_model.sv ----
// Serial port and timer 1 tick model facing the timer 2 block
`timescale 1ns/1ps
`default_nettype none
module tmr2_serial_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Baud ticks
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  output logic timer1_baud_tick,
  // Tick counts
  output logic [15:0] rx_cnt,
  output logic [15:0] tx_cnt,
  output logic [15:0] t1_cnt
);
  logic [4:0] div_r;
  // Default baud source, one tick every 20 cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 5'h00;
      timer1_baud_tick <= 1'h0;
    end else begin
      div_r <= (div_r == 5'h13) ? 5'h00 : div_r + 5'h01;
      timer1_baud_tick <= (div_r == 5'h13);
    end
  end
  // Receiver and transmitter tick counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_cnt <= 16'h0000;
      tx_cnt <= 16'h0000;
      t1_cnt <= 16'h0000;
    end else begin
      rx_cnt <= rx_cnt + {15'h0000, rx_baud_tick};
      tx_cnt <= tx_cnt + {15'h0000, tx_baud_tick};
      t1_cnt <= t1_cnt + {15'h0000, timer1_baud_tick};
    end
  end
endmodule : tmr2_serial_model
`default_nettype wire

// ---- tmr2_top_tb_top.sv ----
// Self-checking testbench for the timer 2 block
`timescale 1ns/1ps
`default_nettype none
module tmr2_top_tb_top;
  import tmr2_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, irq, int_req, int_level;
  logic [1:0] bresp, rresp, rsp;
  logic cnt_pin, cr_pin, int_ack, t1_tick, rx_tick, tx_tick;
  logic [4:0] src_req;
  logic [15:0] int_vector, rx_cnt, tx_cnt, t1_cnt;
  int n_errors, total_checks, cyc;
  tmr2_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .count_input_pin(cnt_pin), .capture_reload_pin(cr_pin), .src_req(src_req),
    .int_ack(int_ack), .int_req(int_req), .int_vector(int_vector), .int_level(int_level),
    .timer1_baud_tick(t1_tick), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick), .irq(irq));
  tmr2_serial_model sp (.aclk(aclk), .aresetn(aresetn), .rx_baud_tick(rx_tick),
    .tx_baud_tick(tx_tick), .timer1_baud_tick(t1_tick), .rx_cnt(rx_cnt), .tx_cnt(tx_cnt),
    .t1_cnt(t1_cnt));
  // ---------------------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_t, w_t, b_t;
    aw_t = 1'h0;
    w_t = 1'h0;
    b_t = 1'h0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!b_t) begin
      @(posedge aclk);
      if (bvalid === 1'h1) begin
        b_t = 1'h1;
        rsp = bresp;
      end
      if (awready === 1'h1 && !aw_t) begin
        aw_t = 1'h1;
        awvalid <= 1'h0;
      end
      if (wready === 1'h1 && !w_t) begin
        w_t = 1'h1;
        wvalid <= 1'h0;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ar_t, r_t;
    ar_t = 1'h0;
    r_t = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    while (!r_t) begin
      @(posedge aclk);
      if (rvalid === 1'h1) begin
        r_t = 1'h1;
        rdat = rdata;
        rsp = rresp;
      end
      if (arready === 1'h1 && !ar_t) begin
        ar_t = 1'h1;
        arvalid <= 1'h0;
      end
    end
  endtask : rd
  task automatic rdck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rdat & m, e);
  endtask : rdck
  task automatic wait_irq(input logic lvl);
    for (int t = 0; t < 300 && irq !== lvl; t++) @(posedge aclk);
  endtask : wait_irq
  task automatic wait_rx;
    int t;
    t = 0;
    do @(posedge aclk); while (rx_tick !== 1'h1 && ++t < 3000);
  endtask : wait_rx
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] codes [14] = '{8'h00, 8'h08, 8'h01, 8'h09, 8'h34, 8'h36, 8'h24, 8'h26,
      8'h14, 8'h16, 8'h02, 8'h0A, 8'h03, 8'h0B};
    for (int i = 0; i < 9; i++) rdck(8'(4 * i), 32'hFFFFFFFF, 32'h0);
    rd(8'h28);
    chk(rdat, 32'h0);
    chk(rsp, RESP_SLVERR);
    wr(8'h28, 8'h5A);
    chk(rsp, RESP_SLVERR);
    foreach (codes[i]) rdck(ADDR_CTRL, 32'hFF, 32'(CTRL_RST));
    foreach (codes[i]) begin
      wr(ADDR_CTRL, codes[i]);
      rdck(ADDR_CTRL, 32'hFF, 32'(codes[i]));
    end
    wr(ADDR_CTRL, 8'h00);
  endtask : t_regs
  task automatic t_baud;
    int c0;
    wr(ADDR_RLD_LO, 8'hF0);
    wr(ADDR_RLD_HI, 8'hFF);
    wr(ADDR_CNT_LO, 8'hF0);
    wr(ADDR_CNT_HI, 8'hFF);
    wr(ADDR_EVT_MASK, 8'h03);
    wr(ADDR_INT_EN, 8'hA0);
    wr(ADDR_CTRL, 8'h34);
    wait_rx();
    c0 = cyc;
    chk(tx_tick, 1'h1);
    wait_rx();
    chk(cyc - c0, 512);
    rdck(ADDR_CTRL, 32'h80, 32'h0);
    chk({irq, int_req}, 2'h0);
    wr(ADDR_CTRL, 8'h00);
  endtask : t_baud
  task automatic t_ext_baud;
    logic [15:0] p0;
    wr(ADDR_RLD_LO, 8'hFF);
    wr(ADDR_CNT_LO, 8'hFF);
    wr(ADDR_CNT_HI, 8'hFF);
    wr(ADDR_CTRL, 8'h36);
    p0 = tx_cnt;
    repeat (16) begin
      cnt_pin <= 1'h0;
      repeat (6) @(posedge aclk);
      cnt_pin <= 1'h1;
      repeat (6) @(posedge aclk);
    end
    repeat (6) @(posedge aclk);
    chk(tx_cnt - p0, 1);
  endtask : t_ext_baud
  task automatic t_one_dir;
    logic [15:0] r0, x0, s0, dd, od;
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL, k ? 8'h24 : 8'h14);
      r0 = rx_cnt;
      x0 = tx_cnt;
      s0 = t1_cnt;
      repeat (400) @(posedge aclk);
      dd = k ? tx_cnt - x0 : rx_cnt - r0;
      od = k ? rx_cnt - r0 : tx_cnt - x0;
      chk(dd + 16'h0001 >= t1_cnt - s0 && dd <= t1_cnt - s0 + 16'h0001, 1);
      chk(od > 16'h0008, 1);
    end
    wr(ADDR_CTRL, 8'h00);
  endtask : t_one_dir
  task automatic t_edge;
    wr(ADDR_CTRL, 8'h3C);
    cr_pin <= 1'h0;
    wait_irq(1'h1);
    rdck(ADDR_CTRL, 32'h40, 32'h40);
    rdck(ADDR_EVT_STAT, 32'h3, 32'h2);
    chk({int_req, int_vector}, 17'h1002B);
    wr(ADDR_EVT_MASK, 8'h01);
    repeat (3) @(posedge aclk);
    chk(irq, 1'h0);
    wr(ADDR_EVT_MASK, 8'h03);
    wait_irq(1'h1);
    wr(ADDR_EVT_STAT, 8'h02);
    wait_irq(1'h0);
    chk(irq, 1'h0);
    wr(ADDR_CTRL, 8'h00);
    repeat (3) @(posedge aclk);
    chk(int_req, 1'h0);
    cr_pin <= 1'h1;
  endtask : t_edge
  task automatic t_reload;
    wr(ADDR_RLD_LO, 8'h00);
    wr(ADDR_RLD_HI, 8'hAB);
    wr(ADDR_CNT_LO, 8'hFE);
    wr(ADDR_CNT_HI, 8'hFF);
    wr(ADDR_CTRL, 8'h04);
    wait_irq(1'h1);
    wr(ADDR_CTRL, 8'h00);
    rdck(ADDR_CNT_HI, 32'hFF, 32'hAB);
    rdck(ADDR_EVT_STAT, 32'h1, 32'h1);
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h0C);
    cr_pin <= 1'h0;
    repeat (10) @(posedge aclk);
    wr(ADDR_CTRL, 8'h08);
    cr_pin <= 1'h1;
    rdck(ADDR_CNT_HI, 32'hFF, 32'hAB);
    wr(ADDR_CNT_HI, 8'h55);
    wr(ADDR_RLD_HI, 8'h00);
    wr(ADDR_CTRL, 8'h09);
    wr(ADDR_CTRL, 8'h0D);
    cr_pin <= 1'h0;
    repeat (10) @(posedge aclk);
    wr(ADDR_CTRL, 8'h00);
    cr_pin <= 1'h1;
    rdck(ADDR_RLD_HI, 32'hFF, 32'h55);
    wr(ADDR_EVT_STAT, 8'h03);
  endtask : t_reload
  task automatic t_vec;
    wr(ADDR_INT_EN, 8'hBF);
    for (int i = 0; i < 5; i++) begin
      src_req <= 5'(1 << i);
      repeat (3) @(posedge aclk);
      chk({int_req, int_vector}, 32'h10003 + 8 * i);
    end
    src_req <= 5'h1F;
    wr(ADDR_INT_PRI, 8'h10);
    repeat (3) @(posedge aclk);
    chk({int_level, int_vector}, 17'h10023);
    src_req <= 5'h00;
    wr(ADDR_INT_PRI, 8'h00);
    wr(ADDR_CTRL, 8'h80);
    repeat (3) @(posedge aclk);
    chk({int_req, int_vector}, 17'h1002B);
    int_ack <= 1'h1;
    @(posedge aclk);
    int_ack <= 1'h0;
    repeat (2) @(posedge aclk);
    rdck(ADDR_CTRL, 32'h80, 32'h80);
    rdck(ADDR_VECT, 32'hFFFF0000, 32'h002B0000);
    wr(ADDR_CTRL, 8'h00);
    repeat (3) @(posedge aclk);
    chk(int_req, 1'h0);
  endtask : t_vec
  task automatic wrap_up;
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // ---------------------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  initial begin
    {awvalid, wvalid, arvalid, int_ack, aresetn} = 5'h00;
    {bready, rready, cnt_pin, cr_pin} = 4'hF;
    {awaddr, araddr, wdata, wstrb, src_req} = {16'h0000, 32'h0, 4'hF, 5'h00};
    {n_errors, total_checks, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    t_baud();
    t_ext_baud();
    t_one_dir();
    t_edge();
    t_reload();
    t_vec();
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    wrap_up();
  end
endmodule : tmr2_top_tb_top
`default_nettype wire
